/* core/plr_regs.sv */
// Local register set of the parallel cable link with transmit framing and receive counters
//
// Summary of operation
// - Status bits 0..6 show live, synchronised cable control lines 0..6.
// - Status bit 7 is high while transmission onto the cable is in progress.
// - Status bits 8..11: transmit empty, almost-empty, almost-full, full, active low.
// - Status bits 12..15: receive empty, almost-empty, almost-full, full, active low.
// - Status bits 16,17 read 1 when the matching identification jumper is fitted.
// - Status bit 21 latches a write to full transmit FIFO; write 1 clears.
// - Status bit 22 latches a read of empty receive FIFO; write 1 clears.
// - Status bit 23 latches a write into full receive FIFO; write 1 clears.
// - Transmit levels: almost-empty 15:0, almost-full 31:16; loaded on transmit FIFO reset.
// - Reset returns both level registers to 0x0010000F and programs the flags.
// - Receive levels share the layout; loaded on every receive FIFO reset.
// - Features word reads 0x3F, reserved upper bits zero.
// - Data port write pushes transmit FIFO; read pops oldest receive word.
// - Software checks not full before writing; writes while full are discarded.
// - Software checks not empty before reading; empty reads return undefined data.
// - Header strobe held for header count clocks at frame start unless line 2 discrete.
// - Row strobe low for gap count, high for row count, alternating; off if line 1 discrete.
// - Receive header counter counts header-strobe clocks of last frame, cleared at frame start.
// - With line 2 discrete it counts all words while reception enabled, else cleared.
// - Receive row counter counts row-strobe clocks of the last received frame.
// - Mask bits 15..0 gate sixteen sources; frame end (bit 1) and receive empty/almost-empty use falling edges.
// - Enabled sources latch in interrupt status until written 1; disabled show live state.
// - Write-one-clear registers clear only the bits written as 1.
`timescale 1ns/1ps
`include "plr_defs.svh"

module plr_regs (
    // Clocks and reset
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               linkClk,
    // Local register port
    input  wire logic               regWrite,
    input  wire logic               regRead,
    input  wire logic [7:0]         regAddr,
    input  wire plr_pkg::plr_word_t regWrData,
    output plr_pkg::plr_word_t      regRdData,
    output logic                    regRdValid,
    // Board pins and board control levels
    input  wire logic [6:0]         cableCtrl,
    input  wire logic [1:0]         boardJumper,
    input  wire logic               line1Discrete,
    input  wire logic               line2Discrete,
    input  wire logic               rxEnable,
    input  wire logic               txBusy,
    input  wire logic               txFifoReset,
    input  wire logic               rxFifoReset,
    // Transmit FIFO
    input  wire logic [3:0]         txFlags,
    output logic                    txPush,
    output plr_pkg::plr_word_t      txWrData,
    output logic [15:0]             txAeLevel,
    output logic [15:0]             txAfLevel,
    output logic                    txLevelLoad,
    // Receive FIFO
    input  wire logic [3:0]         rxFlags,
    input  wire plr_pkg::plr_word_t rxRdData,
    output logic                    rxPop,
    output logic [15:0]             rxAeLevel,
    output logic [15:0]             rxAfLevel,
    output logic                    rxLevelLoad,
    // Cable link, linkClk domain
    input  wire logic               txFrame,
    input  wire logic               rxFramePin,
    input  wire logic               rxHeaderPin,
    input  wire logic               rxRowPin,
    input  wire logic               rxWordPin,
    output logic                    headerStrobe,
    output logic                    rowStrobe
);
    import plr_pkg::*;

    // Set wins over a write-one clear
    function automatic logic [15:0] plrW1c(input logic [15:0] cur, input logic [15:0] set,
                                           input logic [15:0] clr);
        plrW1c = set | (cur & ~clr);
    endfunction

    // ---------------- Register decode ----------------
    wire wrStatus   = regWrite && (regAddr == `PLR_OFF_STATUS);
    wire wrTxLevels = regWrite && (regAddr == `PLR_OFF_TX_LEVELS);
    wire wrRxLevels = regWrite && (regAddr == `PLR_OFF_RX_LEVELS);
    wire wrData     = regWrite && (regAddr == `PLR_OFF_FIFO_DATA);
    wire wrHeader   = regWrite && (regAddr == `PLR_OFF_TX_HEADER);
    wire wrRow      = regWrite && (regAddr == `PLR_OFF_TX_ROW);
    wire wrGap      = regWrite && (regAddr == `PLR_OFF_TX_GAP);
    wire wrMask     = regWrite && (regAddr == `PLR_OFF_IRQ_MASK);
    wire wrIrqStat  = regWrite && (regAddr == `PLR_OFF_IRQ_STATUS);
    wire rdData     = regRead && (regAddr == `PLR_OFF_FIFO_DATA);

    // ---------------- Pin synchronisers, clk domain ----------------
    logic [6:0] ctrlMeta_q, ctrlSync_q;
    logic [1:0] jmpMeta_q, jmpSync_q;
    logic       frmMeta_q, frmSync_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlMeta_q <= 7'h00;
            ctrlSync_q <= 7'h00;
            jmpMeta_q  <= 2'h0;
            jmpSync_q  <= 2'h0;
            frmMeta_q  <= 1'b0;
            frmSync_q  <= 1'b0;
        end else begin
            ctrlMeta_q <= cableCtrl;
            ctrlSync_q <= ctrlMeta_q;
            jmpMeta_q  <= boardJumper;
            jmpSync_q  <= jmpMeta_q;
            frmMeta_q  <= rxFramePin;
            frmSync_q  <= frmMeta_q;
        end
    end

    // ---------------- Writable registers ----------------
    plr_word_t   txLevels_q, rxLevels_q, hdrCount_q, rowCount_q;
    logic [15:0] gapCount_q, irqMask_q;
    logic        cfgToggle_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txLevels_q  <= `PLR_LEVELS_RESET;
            rxLevels_q  <= `PLR_LEVELS_RESET;
            hdrCount_q  <= `PLR_ZERO32;
            rowCount_q  <= `PLR_ZERO32;
            gapCount_q  <= 16'h0000;
            irqMask_q   <= 16'h0000;
            cfgToggle_q <= 1'b0;
        end else begin
            if (wrTxLevels) txLevels_q <= regWrData;
            if (wrRxLevels) rxLevels_q <= regWrData;
            if (wrHeader)   hdrCount_q <= regWrData;
            if (wrRow)      rowCount_q <= regWrData;
            if (wrGap)      gapCount_q <= regWrData[15:0];
            if (wrMask)     irqMask_q  <= regWrData[15:0];
            // Announce new framing counts to the link side
            if (wrHeader || wrRow || wrGap) cfgToggle_q <= ~cfgToggle_q;
        end
    end

    // ---------------- FIFO level programming ----------------
    logic loadPend_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loadPend_q  <= 1'b1;
            txLevelLoad <= 1'b0;
            rxLevelLoad <= 1'b0;
            txAeLevel   <= 16'h0000;
            txAfLevel   <= 16'h0000;
            rxAeLevel   <= 16'h0000;
            rxAfLevel   <= 16'h0000;
        end else begin
            loadPend_q  <= 1'b0;
            txLevelLoad <= loadPend_q | txFifoReset;
            rxLevelLoad <= loadPend_q | rxFifoReset;
            txAeLevel   <= txLevels_q[15:0];
            txAfLevel   <= txLevels_q[31:16];
            rxAeLevel   <= rxLevels_q[15:0];
            rxAfLevel   <= rxLevels_q[31:16];
        end
    end

    // ---------------- Data port ----------------
    wire txFull  = txFlags[3];
    wire rxEmpty = rxFlags[0];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txPush   <= 1'b0;
            txWrData <= `PLR_ZERO32;
            rxPop    <= 1'b0;
        end else begin
            txPush <= wrData && !txFull;
            if (wrData) txWrData <= regWrData;
            rxPop  <= rdData && !rxEmpty;
        end
    end

    // ---------------- Error latches ----------------
    logic [2:0] err_q;
    logic       ovfMeta_q, ovfSync_q, ovfSeen_q;
    logic       ovfToggle_q;
    wire        rxOvfEvent = ovfSync_q ^ ovfSeen_q;
    wire [2:0]  errSet     = {rxOvfEvent, rdData && rxEmpty, wrData && txFull};
    wire [2:0]  errClr     = wrStatus ? regWrData[`PLR_ST_RX_OVERRUN:`PLR_ST_TX_OVERRUN] : 3'h0;
    wire [15:0] errNext    = plrW1c({13'h0000, err_q}, {13'h0000, errSet},
                                    {13'h0000, errClr});
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_q     <= 3'h0;
            ovfMeta_q <= 1'b0;
            ovfSync_q <= 1'b0;
            ovfSeen_q <= 1'b0;
        end else begin
            err_q     <= errNext[2:0];
            ovfMeta_q <= ovfToggle_q;
            ovfSync_q <= ovfMeta_q;
            ovfSeen_q <= ovfSync_q;
        end
    end

    // ---------------- Interrupt sources ----------------
    wire [15:0] srcLevel = {rxFlags, txFlags, ctrlSync_q[6:1], frmSync_q, frmSync_q};
    logic [15:0] srcPrev_q, irqStat_q;
    wire [15:0] srcRise  = srcLevel & ~srcPrev_q;
    wire [15:0] srcFall  = srcPrev_q & ~srcLevel;
    wire [15:0] srcEdge  = (srcRise & ~`PLR_IRQ_FALLING) | (srcFall & `PLR_IRQ_FALLING);
    wire [15:0] srcLive  = srcLevel ^ `PLR_IRQ_FALLING;
    wire [15:0] irqClr   = wrIrqStat ? regWrData[15:0] : 16'h0000;
    wire [15:0] irqNext  = plrW1c(irqStat_q, srcEdge, irqClr) & irqMask_q;
    wire [15:0] irqView  = (irqStat_q & irqMask_q) | (srcLive & ~irqMask_q);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            srcPrev_q <= 16'h0000;
            irqStat_q <= 16'h0000;
        end else begin
            srcPrev_q <= srcLevel;
            irqStat_q <= irqNext;
        end
    end

    // ---------------- Receive counters from the link ----------------
    plr_word_t rxHdrView_q, rxRowView_q, hdrHold_q, rowHold_q;
    logic      hsMeta_q, hsSync_q, hsSeen_q, hsReq_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hsMeta_q    <= 1'b0;
            hsSync_q    <= 1'b0;
            hsSeen_q    <= 1'b0;
            rxHdrView_q <= `PLR_ZERO32;
            rxRowView_q <= `PLR_ZERO32;
        end else begin
            hsMeta_q <= hsReq_q;
            hsSync_q <= hsMeta_q;
            if (hsSync_q != hsSeen_q) begin
                // Hold words are stable until this acknowledge returns
                rxHdrView_q <= hdrHold_q;
                rxRowView_q <= rowHold_q;
                hsSeen_q    <= hsSync_q;
            end
        end
    end

    // ---------------- Read mux ----------------
    wire [31:0] statusWord = {8'h00, err_q, 3'h0, jmpSync_q, ~rxFlags, ~txFlags, txBusy,
                              ctrlSync_q};
    logic [31:0] rdMux;
    always_comb begin
        unique case (regAddr)
            `PLR_OFF_STATUS:     rdMux = statusWord;
            `PLR_OFF_TX_LEVELS:  rdMux = txLevels_q;
            `PLR_OFF_RX_LEVELS:  rdMux = rxLevels_q;
            `PLR_OFF_FEATURES:   rdMux = `PLR_FEATURES_VALUE;
            `PLR_OFF_FIFO_DATA:  rdMux = rxRdData;
            `PLR_OFF_TX_HEADER:  rdMux = hdrCount_q;
            `PLR_OFF_TX_ROW:     rdMux = rowCount_q;
            `PLR_OFF_TX_GAP:     rdMux = {16'h0000, gapCount_q};
            `PLR_OFF_RX_HEADER:  rdMux = rxHdrView_q;
            `PLR_OFF_RX_ROW:     rdMux = rxRowView_q;
            `PLR_OFF_IRQ_MASK:   rdMux = {16'h0000, irqMask_q};
            `PLR_OFF_IRQ_STATUS: rdMux = {16'h0000, irqView};
            default:             rdMux = `PLR_ZERO32;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData  <= `PLR_ZERO32;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) regRdData <= rdMux;
        end
    end

    // ================ Link clock domain ================
    logic [6:0] lnkMeta_q, lnkSync_q;
    logic [2:0] cfgSync_q;
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            lnkMeta_q <= 7'h00;
            lnkSync_q <= 7'h00;
            cfgSync_q <= 3'h0;
        end else begin
            lnkMeta_q <= {rxFlags[3], rxEnable, line2Discrete, line1Discrete,
                          rxWordPin, rxRowPin, rxHeaderPin};
            lnkSync_q <= lnkMeta_q;
            cfgSync_q <= {cfgSync_q[1:0], cfgToggle_q};
        end
    end
    wire lHeader = lnkSync_q[0];
    wire lRow    = lnkSync_q[1];
    wire lWord   = lnkSync_q[2];
    wire lLine1  = lnkSync_q[3];
    wire lLine2  = lnkSync_q[4];
    wire lRxEn   = lnkSync_q[5];
    wire lRxFull = lnkSync_q[6];

    // Framing counts copied across; a rewrite within a few link clocks is unsafe
    plr_word_t   lHdrCnt_q, lRowCnt_q;
    logic [15:0] lGapCnt_q;
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            lHdrCnt_q <= `PLR_ZERO32;
            lRowCnt_q <= `PLR_ZERO32;
            lGapCnt_q <= 16'h0000;
        end else if (cfgSync_q[2] != cfgSync_q[1]) begin
            lHdrCnt_q <= hdrCount_q;
            lRowCnt_q <= rowCount_q;
            lGapCnt_q <= gapCount_q;
        end
    end

    // ---------------- Transmit framing ----------------
    plr_frame_state_t state_q, state_d;
    plr_word_t        phase_q, phase_d;
    logic             txFramePrev_q;
    wire              frameStart = txFrame && !txFramePrev_q;
    wire              phaseDone  = (phase_q <= `PLR_ONE32);
    always_comb begin
        state_d = state_q;
        phase_d = phase_q - `PLR_ONE32;
        unique case (state_q)
            PLR_IDLE: begin
                phase_d = phase_q;
                if (frameStart && !lLine2 && lHdrCnt_q != `PLR_ZERO32) begin
                    state_d = PLR_HEADER;
                    phase_d = lHdrCnt_q;
                end else if (frameStart) begin
                    state_d = PLR_GAP;
                    phase_d = {16'h0000, lGapCnt_q};
                end
            end
            PLR_HEADER: if (phaseDone) begin
                state_d = PLR_GAP;
                phase_d = {16'h0000, lGapCnt_q};
            end
            PLR_GAP: if (phaseDone) begin
                state_d = PLR_ROW;
                phase_d = lRowCnt_q;
            end
            PLR_ROW: if (phaseDone) begin
                state_d = PLR_GAP;
                phase_d = {16'h0000, lGapCnt_q};
            end
        endcase
        if (!txFrame) begin
            state_d = PLR_IDLE;
            phase_d = `PLR_ZERO32;
        end
    end
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            state_q       <= PLR_IDLE;
            phase_q       <= `PLR_ZERO32;
            txFramePrev_q <= 1'b0;
            headerStrobe  <= 1'b0;
            rowStrobe     <= 1'b0;
        end else begin
            state_q       <= state_d;
            phase_q       <= phase_d;
            txFramePrev_q <= txFrame;
            headerStrobe  <= (state_d == PLR_HEADER);
            rowStrobe     <= (state_d == PLR_ROW) && !lLine1;
        end
    end

    // ---------------- Receive counting ----------------
    logic      rxFrmMeta_q, rxFrm_q, rxFrmPrev_q;
    plr_word_t rxHdrCnt_q, rxRowCnt_q;
    logic      ackMeta_q, ackSync_q;
    wire       rxStart = rxFrm_q && !rxFrmPrev_q;
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            rxFrmMeta_q <= 1'b0;
            rxFrm_q     <= 1'b0;
            rxFrmPrev_q <= 1'b0;
            rxHdrCnt_q  <= `PLR_ZERO32;
            rxRowCnt_q  <= `PLR_ZERO32;
            ovfToggle_q <= 1'b0;
        end else begin
            rxFrmMeta_q <= rxFramePin;
            rxFrm_q     <= rxFrmMeta_q;
            rxFrmPrev_q <= rxFrm_q;
            if (lLine2) begin
                if (!lRxEn) rxHdrCnt_q <= `PLR_ZERO32;
                else if (lWord) rxHdrCnt_q <= rxHdrCnt_q + `PLR_ONE32;
            end else if (rxStart) begin
                rxHdrCnt_q <= lHeader ? `PLR_ONE32 : `PLR_ZERO32;
            end else if (rxFrm_q && lHeader) begin
                rxHdrCnt_q <= rxHdrCnt_q + `PLR_ONE32;
            end
            if (rxStart) rxRowCnt_q <= lRow ? `PLR_ONE32 : `PLR_ZERO32;
            else if (rxFrm_q && lRow) rxRowCnt_q <= rxRowCnt_q + `PLR_ONE32;
            if (lWord && lRxFull) ovfToggle_q <= ~ovfToggle_q;
        end
    end

    // Word handshake: a new snapshot leaves only after the last one was taken
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            hsReq_q   <= 1'b0;
            ackMeta_q <= 1'b0;
            ackSync_q <= 1'b0;
            hdrHold_q <= `PLR_ZERO32;
            rowHold_q <= `PLR_ZERO32;
        end else begin
            ackMeta_q <= hsSeen_q;
            ackSync_q <= ackMeta_q;
            if (ackSync_q == hsReq_q) begin
                hdrHold_q <= rxHdrCnt_q;
                rowHold_q <= rxRowCnt_q;
                hsReq_q   <= ~hsReq_q;
            end
        end
    end

endmodule // plr_regs

/* common/plr_defs.svh */
// Offsets, field positions, reset values and constants of the local register set
`ifndef PLR_DEFS_SVH
`define PLR_DEFS_SVH

`define PLR_OFF_STATUS      8'h08
`define PLR_OFF_TX_LEVELS   8'h0C
`define PLR_OFF_RX_LEVELS   8'h10
`define PLR_OFF_FEATURES    8'h14
`define PLR_OFF_FIFO_DATA   8'h18
`define PLR_OFF_TX_HEADER   8'h1C
`define PLR_OFF_TX_ROW      8'h20
`define PLR_OFF_TX_GAP      8'h24
`define PLR_OFF_RX_HEADER   8'h28
`define PLR_OFF_RX_ROW      8'h2C
`define PLR_OFF_IRQ_MASK    8'h30
`define PLR_OFF_IRQ_STATUS  8'h34

`define PLR_LEVELS_RESET    32'h0010000F
`define PLR_FEATURES_VALUE  32'h0000003F
`define PLR_ZERO32          32'h00000000
`define PLR_ONE32           32'h00000001

`define PLR_ST_TX_BUSY      7
`define PLR_ST_TX_FLAGS     8
`define PLR_ST_RX_FLAGS     12
`define PLR_ST_JUMPER       16
`define PLR_ST_TX_OVERRUN   21
`define PLR_ST_RX_UNDERRUN  22
`define PLR_ST_RX_OVERRUN   23
`define PLR_ST_ERR_MASK     32'h00E00000

`define PLR_IRQ_FALLING     16'h3002

`endif

/* common/plr_pkg.sv */
// Types of the local register set
package plr_pkg;

    // Transmit framing phases, Gray along idle-header-gap-row
    typedef enum logic [1:0] {
        PLR_IDLE   = 2'b00,
        PLR_HEADER = 2'b01,
        PLR_GAP    = 2'b11,
        PLR_ROW    = 2'b10
    } plr_frame_state_t;

    typedef logic [31:0] plr_word_t;

endpackage

/* tb/plr_regs_properties.sv */
// Port-level checks of the local register block
`timescale 1ns/1ps
module plr_regs_props (
    input wire logic clk, rst, regWrite, regRead, regRdValid, txPush, rxPop,
    input wire logic txFifoReset, rxFifoReset, txLevelLoad, rxLevelLoad,
    input wire logic [7:0] regAddr,
    input wire logic [3:0] txFlags, rxFlags,
    input wire plr_pkg::plr_word_t regWrData, regRdData, rxRdData, txWrData
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire dataWr = regWrite && regAddr == 8'h18;
    wire dataRd = regRead && regAddr == 8'h18;
    property p_rd_ans; (regRead |=> regRdValid) and (!regRead |=> !regRdValid); endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer");
    property p_push; dataWr && !txFlags[3] |=> txPush && txWrData == $past(regWrData); endproperty
    a_push: assert property (p_push) else $error("push missing");
    property p_nopush; dataWr && txFlags[3] |=> !txPush; endproperty
    a_nopush: assert property (p_nopush) else $error("push when full");
    property p_pop; dataRd && !rxFlags[0] |=> rxPop && regRdData == $past(rxRdData); endproperty
    a_pop: assert property (p_pop) else $error("pop missing");
    property p_nopop; dataRd && rxFlags[0] |=> !rxPop; endproperty
    a_nopop: assert property (p_nopop) else $error("pop when empty");
    property p_flags; regRead && regAddr == 8'h08 |=>
        regRdData[15:8] == ~{$past(rxFlags), $past(txFlags)}; endproperty
    a_flags: assert property (p_flags) else $error("status flags");
    property p_txload; txFifoReset |=> txLevelLoad; endproperty
    a_txload: assert property (p_txload) else $error("tx level load");
    property p_rxload; rxFifoReset |=> rxLevelLoad; endproperty
    a_rxload: assert property (p_rxload) else $error("rx level load");
    property p_feat; regRead && regAddr == 8'h14 |=> regRdData == 32'h0000003F; endproperty
    a_feat: assert property (p_feat) else $error("features word");
endmodule // plr_regs_props

bind plr_regs plr_regs_props i_props (.*);

/* tb/plr_fifo_model.sv */
// Behavioural transmit and receive FIFOs behind the register block
`timescale 1ns/1ps
module plr_fifo_model #(parameter int DEPTH = 4) (
    input  wire logic               clk, rst, txPush, rxPop, rxPut,
    input  wire plr_pkg::plr_word_t txWrData, rxPutData,
    output logic [3:0]              txFlags, rxFlags,
    output plr_pkg::plr_word_t      rxRdData
);
    import plr_pkg::*;
    plr_word_t txQ[$];
    plr_word_t rxQ[$];
    plr_word_t lastRx;
    function automatic logic [3:0] flagsOf(input int n);
        return {n == DEPTH, n >= DEPTH - 1, n <= 1, n == 0};
    endfunction
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            txQ.delete();
            rxQ.delete();
            lastRx = 32'h00000000;
        end else begin
            if (txPush && txQ.size() < DEPTH) txQ.push_back(txWrData);
            if (rxPop && rxQ.size() > 0) lastRx = rxQ.pop_front();
            if (rxPut && rxQ.size() < DEPTH) rxQ.push_back(rxPutData);
        end
        txFlags <= flagsOf(txQ.size());
        rxFlags <= flagsOf(rxQ.size());
        // Empty head is junk, never a stale copy
        rxRdData <= rxQ.size() > 0 ? rxQ[0] : ~lastRx;
    end
endmodule // plr_fifo_model

/* tb/plr_regs_tb.sv */
// Self-checking bench of the local register block
`timescale 1ns/1ps
module plr_regs_tb;
    import plr_pkg::*;
    logic clk = 0, rst = 1, linkClk = 0, regWrite = 0, regRead = 0, txBusy = 0;
    logic txFifoReset = 0, rxFifoReset = 0, txFrame = 0, rxPut = 0;
    logic rxFramePin = 0, rxHeaderPin = 0, rxRowPin = 0, rxWordPin = 0;
    logic line1Discrete = 0, line2Discrete = 0, rxEnable = 0;
    logic regRdValid, txPush, rxPop, txLevelLoad, rxLevelLoad, headerStrobe, rowStrobe;
    logic [7:0] regAddr = 0;
    logic [6:0] cableCtrl = 0;
    logic [1:0] boardJumper = 0;
    logic [3:0] txFlags, rxFlags;
    logic [15:0] txAeLevel, txAfLevel, rxAeLevel, rxAfLevel;
    plr_word_t regWrData = 0, rxPutData = 0, regRdData, txWrData, rxRdData, v;
    plr_word_t q[$];
    int n_errors = 0, checks_done = 0, h, g, r;
    initial forever #5 clk = ~clk;
    initial begin
        #7;
        forever #80 linkClk = ~linkClk;
    end
    plr_regs i_dut (.*);
    plr_fifo_model i_fifo (.*);
    task automatic chk(input plr_word_t got, input plr_word_t exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input plr_word_t d);
        regWrite <= 1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk) regWrite <= 0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input plr_word_t e, input plr_word_t m);
        regRead <= 1;
        regAddr <= a;
        @(posedge clk) regRead <= 0;
        #1 chk(regRdData & m, e);
        chk(regRdValid, 1);
        @(posedge clk);
    endtask
    task automatic put(input int n);
        repeat (n) begin
            rxPutData <= $urandom;
            rxPut <= 1;
            @(posedge clk) q.push_back(rxPutData);
        end
        rxPut <= 0;
        @(posedge clk);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        n_errors++;
        conclude();
    end
    initial begin
        void'($urandom(22478));
        // Long enough for the link domain to see reset too
        repeat (3) @(posedge linkClk);
        @(posedge clk) rst <= 0;
        @(posedge clk);
        rc(8'h0C, 32'h0010000F, '1);
        rc(8'h10, 32'h0010000F, '1);
        rc(8'h14, 32'h0000003F, '1);
        rc(8'h3C, 32'h00000000, '1);
        wr(8'h24, 32'hFFFFFFFF);
        rc(8'h24, 32'h0000FFFF, '1);
        wr(8'h30, 32'hFFFFFFFF);
        rc(8'h30, 32'h0000FFFF, '1);
        v = $urandom;
        wr(8'h0C, v);
        wr(8'h10, ~v);
        txFifoReset <= 1;
        rxFifoReset <= 1;
        @(posedge clk) txFifoReset <= 0;
        rxFifoReset <= 0;
        repeat (2) @(posedge clk);
        chk({txAfLevel, txAeLevel}, v);
        chk({rxAfLevel, rxAeLevel}, ~v);
        cableCtrl <= $urandom;
        boardJumper <= $urandom;
        txBusy <= 1;
        repeat (4) @(posedge clk);
        rc(8'h08, {14'h0, boardJumper, ~rxFlags, ~txFlags, 1'b1, cableCtrl}, '1);
        // Fifth word meets a full transmit FIFO
        repeat (5) begin
            v = $urandom;
            if (q.size() < 4) q.push_back(v);
            wr(8'h18, v);
        end
        chk(i_fifo.txQ.size(), 4);
        foreach (q[i]) chk(i_fifo.txQ[i], q[i]);
        q.delete();
        put(2);
        repeat (2) rc(8'h18, q.pop_front(), '1);
        rc(8'h18, 32'h00000000, 32'h00000000);
        put(4);
        @(posedge linkClk) rxWordPin <= 1;
        @(posedge linkClk) rxWordPin <= 0;
        repeat (3) @(posedge linkClk);
        @(posedge clk);
        rc(8'h08, 32'h00E00000, 32'h00E00000);
        wr(8'h08, 32'h00200000);
        rc(8'h08, 32'h00C00000, 32'h00E00000);
        h = 1 + $urandom % 3;
        g = 1 + $urandom % 3;
        r = 1 + $urandom % 3;
        wr(8'h1C, h);
        wr(8'h24, g);
        wr(8'h20, r);
        repeat (8) @(posedge linkClk);
        txFrame <= 1;
        @(posedge linkClk);
        for (int i = 0; i < 14; i++) begin
            #1;
            chk({headerStrobe, rowStrobe}, {i < h, i >= h && (i - h) % (g + r) >= g});
            @(posedge linkClk);
        end
        txFrame <= 0;
        @(posedge linkClk) #1 chk({headerStrobe, rowStrobe}, 0);
        rxFramePin <= 1;
        for (int i = 0; i < 9; i++) begin
            @(posedge linkClk) rxHeaderPin <= i < 3;
            rxRowPin <= i >= 4 && i < 8;
        end
        rxFramePin <= 0;
        repeat (10) @(posedge linkClk);
        @(posedge clk);
        rc(8'h28, 32'h00000003, '1);
        rc(8'h2C, 32'h00000004, '1);
        // Discrete line 2: word count while enabled, cleared while disabled
        line2Discrete <= 1;
        repeat (4) @(posedge linkClk);
        rxEnable <= 1;
        repeat (4) @(posedge linkClk);
        rxWordPin <= 1;
        repeat (3) @(posedge linkClk);
        rxWordPin <= 0;
        repeat (10) @(posedge linkClk);
        @(posedge clk);
        rc(8'h28, 32'h00000003, '1);
        rxEnable <= 0;
        repeat (6) @(posedge linkClk);
        @(posedge clk);
        rc(8'h28, 32'h00000000, '1);
        conclude();
    end
endmodule // plr_regs_tb
